// File: design/ddrs_pkg.sv
// ============================================================
// shared constants and types for the burst-of-four sram core
package ddrs_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_STOP_NS = 30;
  // static clock longer than the stop time, in whole cycles
  localparam int CLK_STOP_CYC = CLK_STOP_NS / CLK_PERIOD_NS;
  localparam int DLL_LOCK_K_CYCLES = 2048;
  // burst layout
  localparam int BURST_LEN = 4;
  localparam logic [3:0] RD_FIRST_HALF = 4'h3;
  localparam logic [3:0] WR_FIRST_HALF = 4'h8;
  localparam logic [3:0] HALF_MAX = 4'hF;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam int ADDR_W_DEF = 21;
  localparam int DATA_W_DEF = 36;
  localparam int NUM_TRK_DEF = 3;

  typedef enum logic [1:0] {DDRS_DLL_RESET, DDRS_DLL_LOCKING, DDRS_DLL_READY} ddrs_dll_state_t;

  // rising edges seen on the sampled clock pins
  typedef struct packed {
    logic k;
    logic kn;
    logic c;
    logic cn;
  } ddrs_edge_t;
endpackage : ddrs_pkg

// File: design/ddrs_burst_trk.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// one outstanding burst: half-cycle timer, beat counter, address
module ddrs_burst_trk import ddrs_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic start_read,
  input wire logic [ADDR_W-1:0] start_addr,
  input wire ddrs_edge_t edges,
  output logic busy,
  output logic is_read,
  output logic fire,
  output logic [ADDR_W-1:0] beat_addr
);
  logic busy_q, busy_d, rd_q, rd_d;
  logic [ADDR_W-1:0] base_q, base_d;
  // last beat address, held apart from base_q so the wrap check is not a copy of the datapath
  logic [ADDR_W-1:0] prev_q, prev_d;
  logic [1:0] beat_q, beat_d;
  logic [3:0] half_q, half_d;
  logic tick;
  logic [3:0] half_now;

  // ============================================================
  // next state: timing counts both k and k# rises as half cycles
  always_comb begin
    tick = edges.k | edges.kn;
    half_now = half_q + {3'h0, tick & (half_q != HALF_MAX)};
    busy_d = busy_q;
    rd_d = rd_q;
    base_d = base_q;
    beat_d = beat_q;
    half_d = busy_q ? half_now : half_q;
    if (rd_q) begin
      // even beats leave on c#, odd ones on c
      fire = busy_q && (beat_q[0] ? edges.c : edges.cn) && (half_now >= RD_FIRST_HALF + {2'h0, beat_q}); // [RULE9]
    end else begin
      // late write: beats land on k/k# from t+4.0 onward
      fire = busy_q && tick && (half_now == WR_FIRST_HALF + {2'h0, beat_q}); // [RULE10]
    end
    if (fire) begin
      beat_d = beat_q + 2'h1;
      if (beat_q == LAST_BEAT) begin
        busy_d = 1'b0;
      end
    end
    prev_d = fire ? beat_addr : prev_q;
    if (start) begin
      busy_d = 1'b1;
      rd_d = start_read;
      base_d = start_addr;
      beat_d = 2'h0;
      half_d = 4'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      base_q <= '0;
      beat_q <= 2'h0;
      half_q <= 4'h0;
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
      busy_q <= busy_d;
      rd_q <= rd_d;
      base_q <= base_d;
      beat_q <= beat_d;
      half_q <= half_d;
    end
  end

  // linear order, wrapping in the two low bits only
  assign beat_addr = {base_q[ADDR_W-1:2], base_q[1:0] + beat_q}; // [RULE7]
  assign busy = busy_q;
  assign is_read = rd_q;

  // ============================================================
  // checks
  a_burst_wrap: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
    (fire && beat_q != 2'h0) |-> (beat_addr == {prev_q[ADDR_W-1:2], prev_q[1:0] + 2'h1}))
    else $error("burst address left the linear wrap");
  a_write_beat_k: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
    (fire && !rd_q) |-> (edges.k == !beat_q[0]) && (edges.kn == beat_q[0]))
    else $error("write beat not on the expected k edge");
  a_read_beat_c: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    (fire && rd_q) |-> (half_now >= 4'h3) && (beat_q[0] ? edges.c : edges.cn))
    else $error("read beat early or on the wrong output clock");
  a_burst_four: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
    (fire && beat_q == 2'h3 && !start) |=> !busy_q)
    else $error("burst did not end after four beats");
endmodule : ddrs_burst_trk
`default_nettype wire

// File: design/ddrs_core.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// [RULE1] either k pin static longer than 30 ns resets the dll and prepares a re-lock.
// [RULE2] a low-to-high step on dll_off_n resets the dll, which then locks again.
// [RULE3] after a dll reset the part waits out dll_lock_period before normal use.
// [RULE4] if dll_off_n rose before the clock settled, the controller resets the dll once it is stable.
// [RULE5] after a frequency change without power cycling the controller runs a dll reset sequence.
// [RULE6] during power-on every input is held at a clean high or low level.
// [RULE7] the burst counter gives start +0, +1, +2, +3, wrapping in the two low address bits.
// [RULE8] address and command are taken on a k rise only while load_strobe_n is low.
// [RULE9] a read load drives beats on c# t+1.5, c t+2.0, c# t+2.5 and c t+3.0.
// [RULE10] a write load captures beats on k t+4.0, k# t+4.5, k t+5.0 and k# t+5.5.
// [RULE11] the controller lets every pending burst finish before stopping the clocks.
// [RULE12] a nop does not cut a running read, and the drivers turn off once it completes.
module ddrs_core import ddrs_pkg::*; #(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int NUM_TRK = NUM_TRK_DEF,
  parameter int LOCK_CYCLES = DLL_LOCK_K_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic c_clk,
  input wire logic c_clk_n,
  input wire logic dll_off_n,
  input wire logic load_strobe_n,
  input wire logic rw_strobe,
  input wire logic [ADDR_W-1:0] sync_address,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic dll_ready
);
  // ============================================================
  // pin edge detection
  ddrs_edge_t pins_q, pins_now, edges;
  logic doff_q;

  always_comb begin
    pins_now = '{k: k_clk, kn: k_clk_n, c: c_clk, cn: c_clk_n};
    edges = pins_now & ~pins_q;
  end

  // disable pin history resets to its idle high level, so no false rise follows reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pins_q <= '0;
      doff_q <= 1'b1;
    end else begin
      pins_q <= pins_now;
      doff_q <= dll_off_n;
    end
  end

  // ============================================================
  // dll reset and lock sequencing
  ddrs_dll_state_t dll_q, dll_d;
  logic [3:0] k_idle_q, k_idle_d, kn_idle_q, kn_idle_d;
  logic [15:0] lock_q, lock_d;
  logic clk_stopped, doff_rise;

  always_comb begin
    // idle counters saturate so a long stop never wraps back to "running"
    k_idle_d = (pins_now.k != pins_q.k) ? 4'h0 : k_idle_q + {3'h0, k_idle_q != 4'hF};
    kn_idle_d = (pins_now.kn != pins_q.kn) ? 4'h0 : kn_idle_q + {3'h0, kn_idle_q != 4'hF};
    clk_stopped = (k_idle_q > 4'(CLK_STOP_CYC)) || (kn_idle_q > 4'(CLK_STOP_CYC)); // [RULE1]
    doff_rise = dll_off_n && !doff_q; // [RULE2]
    dll_d = dll_q;
    lock_d = lock_q;
    case (dll_q)
      DDRS_DLL_RESET: begin
        lock_d = 16'h0000;
        if (!clk_stopped && !doff_rise) begin
          dll_d = DDRS_DLL_LOCKING;
        end
      end
      DDRS_DLL_LOCKING: begin
        // only k rises of a running clock count toward the lock time
        if (edges.k) begin
          lock_d = lock_q + 16'h0001;
        end
        if (edges.k && lock_q == 16'(LOCK_CYCLES - 1)) begin
          dll_d = DDRS_DLL_READY; // [RULE3]
        end
      end
      DDRS_DLL_READY: begin
        lock_d = lock_q;
      end
      default: begin
        dll_d = DDRS_DLL_RESET;
      end
    endcase
    if (clk_stopped || doff_rise) begin
      dll_d = DDRS_DLL_RESET; // [RULE1] [RULE2]
      lock_d = 16'h0000;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dll_q <= DDRS_DLL_RESET;
      k_idle_q <= 4'h0;
      kn_idle_q <= 4'h0;
      lock_q <= 16'h0000;
    end else begin
      dll_q <= dll_d;
      k_idle_q <= k_idle_d;
      kn_idle_q <= kn_idle_d;
      lock_q <= lock_d;
    end
  end

  assign dll_ready = (dll_q == DDRS_DLL_READY);

  // ============================================================
  // command decode and tracker allocation
  logic load;
  logic [1:0] ptr_q, ptr_d;
  logic [NUM_TRK-1:0] trk_start, trk_busy, trk_rd, trk_fire;
  logic [ADDR_W-1:0] trk_addr [NUM_TRK];

  always_comb begin
    // loads come at most every other k cycle, so round robin never hits a live slot
    load = dll_ready && edges.k && !load_strobe_n; // [RULE8] [RULE3]
    trk_start = '0;
    ptr_d = ptr_q;
    if (load) begin
      trk_start[ptr_q] = 1'b1;
      ptr_d = (ptr_q == 2'(NUM_TRK - 1)) ? 2'h0 : ptr_q + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 2'h0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  for (genvar g = 0; g < NUM_TRK; g++) begin : g_trk
    ddrs_burst_trk #(.ADDR_W(ADDR_W)) u_trk (
      .clock(clock),
      .rst_n(rst_n),
      .start(trk_start[g]),
      .start_read(rw_strobe),
      .start_addr(sync_address),
      .edges(edges),
      .busy(trk_busy[g]),
      .is_read(trk_rd[g]),
      .fire(trk_fire[g]),
      .beat_addr(trk_addr[g])
    );
  end

  // ============================================================
  // storage and data beats
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic rd_fire, wr_fire;
  logic [ADDR_W-1:0] rd_addr, wr_addr;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic oe_q, oe_d;

  always_comb begin
    rd_fire = 1'b0;
    wr_fire = 1'b0;
    rd_addr = '0;
    wr_addr = '0;
    for (int i = 0; i < NUM_TRK; i++) begin
      if (trk_fire[i] && trk_rd[i]) begin
        rd_fire = 1'b1;
        rd_addr = trk_addr[i];
      end
      if (trk_fire[i] && !trk_rd[i]) begin
        wr_fire = 1'b1;
        wr_addr = trk_addr[i];
      end
    end
    dout_d = rd_fire ? mem[rd_addr] : dout_q; // [RULE9]
    // drivers stay on through a nop and fall at the first c or c# rise that carries no read beat
    oe_d = oe_q;
    if (rd_fire) begin
      oe_d = 1'b1;
    end else if (edges.c || edges.cn) begin
      oe_d = 1'b0; // [RULE12]
    end
  end

  // array has no reset; contents are undefined at power-up as in any sram
  always_ff @(posedge clock) begin
    if (wr_fire) begin
      mem[wr_addr] <= data_in; // [RULE10]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dout_q <= '0;
      oe_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      oe_q <= oe_d;
    end
  end

  assign data_out = dout_q;
  assign data_oe = oe_q;

  // ============================================================
  // checks
  a_stop_resets_dll: assert property (@(posedge clock) disable iff (!rst_n) // [RULE1]
    (k_idle_q == 4'(CLK_STOP_CYC + 1)) |=> (dll_q == DDRS_DLL_RESET))
    else $error("stopped k did not reset the dll");
  a_doff_resets_dll: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (dll_off_n && !$past(dll_off_n) && doff_q == 1'b0) |=> !dll_ready)
    else $error("dll_off_n rise did not reset the dll");
  a_ready_after_lock: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
    $rose(dll_ready) |-> ($past(lock_q) == 16'(LOCK_CYCLES - 1)) && $past(edges.k))
    else $error("ready before the lock period elapsed");
  a_load_needs_low: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    (|trk_start) |-> (!load_strobe_n && edges.k && dll_ready))
    else $error("burst started without a qualified load");
  a_nop_no_start: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
    (load_strobe_n || !edges.k) |-> (trk_start == '0))
    else $error("nop or non-k cycle started a burst");
  a_read_drives_out: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
    rd_fire |=> data_oe && (data_out == $past(mem[rd_addr])))
    else $error("read beat not driven on the next cycle");
  a_oe_turns_off: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
    (!rd_fire && (edges.c || edges.cn)) |=> !data_oe)
    else $error("drivers stayed on after the burst");
  a_write_stores: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
    wr_fire |=> (mem[$past(wr_addr)] == $past(data_in)))
    else $error("write beat not stored");
endmodule : ddrs_core
`default_nettype wire

// File: testbench/ddrs_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// controller model: k pair, one command at a time, late-write beats
module ddrs_ctrl_model import ddrs_pkg::*; (
  input wire logic clock,
  input wire logic run,
  input wire logic go,
  input wire logic go_rd,
  input wire logic [5:0] go_addr,
  input wire logic [3:0][DATA_W_DEF-1:0] go_wd,
  // every pin starts at a clean level, with one driver each
  output logic k_clk = 1'b1,
  output logic k_clk_n = 1'b0,
  output logic load_strobe_n = 1'b1,
  output logic rw_strobe = 1'b0,
  output logic [5:0] sync_address = 6'h00,
  output logic [DATA_W_DEF-1:0] data_in = '0,
  output logic taken = 1'b0
);
  logic [1:0] ph = 2'h0;
  logic [3:0] half = 4'hF;
  logic wr = 1'b0;
  // moves on the falling edge; a stop waits for owed write beats
  always @(negedge clock) begin
    if (run || wr) begin
      ph <= ph + 2'h1;
      k_clk <= (ph == 2'h3) || (ph == 2'h0);
      k_clk_n <= (ph == 2'h1) || (ph == 2'h2);
      if ((ph == 2'h3 || ph == 2'h1) && half != 4'hF) half <= half + 4'h1;
    end
    // write beats on the 8th to 11th half after the load
    if (wr && (ph == 2'h3 || ph == 2'h1) && half >= 4'h7 && half <= 4'hA) begin
      data_in <= go_wd[2'(half - 4'h7)];
      if (half == 4'hA) wr <= 1'b0;
    end else begin
      data_in <= ~data_in; // no stale data between beats
    end
    // load only on a k rise
    if (run && ph == 2'h3 && go && !taken) begin
      load_strobe_n <= 1'b0;
      rw_strobe <= go_rd;
      sync_address <= go_addr;
      taken <= 1'b1;
      half <= 4'h0;
      wr <= !go_rd;
    end else begin
      load_strobe_n <= 1'b1;
      rw_strobe <= ~rw_strobe;
      sync_address <= ~sync_address;
      if (taken && !go) taken <= 1'b0;
    end
  end
endmodule : ddrs_ctrl_model
`default_nettype wire

// File: testbench/test_ddr_cio_sram_burst_and_dll_reset.sv
`timescale 1ns/1ns
`default_nettype none
module test_ddr_cio_sram_burst_and_dll_reset import ddrs_pkg::*; ;
  logic clock, rst_n, run, go, go_rd, dll_off_n, k, kn, ld_n, rw, taken, data_oe, dll_ready;
  logic [5:0] go_addr, sa;
  logic [3:0][35:0] go_wd;
  logic [35:0] din, data_out;
  logic [35:0] mem [64];
  logic [5:0] alist [5];
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h13;
  ddrs_ctrl_model u_ddrs_ctrl_model (.clock(clock), .run(run), .go(go), .go_rd(go_rd), .go_addr(go_addr),
    .go_wd(go_wd), .k_clk(k), .k_clk_n(kn), .load_strobe_n(ld_n), .rw_strobe(rw), .sync_address(sa),
    .data_in(din), .taken(taken));
  ddrs_core #(.ADDR_W(6), .DATA_W(36), .LOCK_CYCLES(4)) u_ddrs_core (.clock(clock), .rst_n(rst_n),
    .k_clk(k), .k_clk_n(kn), .c_clk(k), .c_clk_n(kn), .dll_off_n(dll_off_n), .load_strobe_n(ld_n),
    .rw_strobe(rw), .sync_address(sa), .data_in(din), .data_out(data_out), .data_oe(data_oe),
    .dll_ready(dll_ready));
  // ============================================================
  // helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // burst order wraps in the two low bits only
  function automatic logic [5:0] ba(input logic [5:0] a, input int n);
    return {a[5:2], a[1:0] + 2'(n)};
  endfunction : ba
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // hold the request until the model reports it loaded; ends just after cycle 0
  task automatic cmd(input logic rd, input logic [5:0] a);
    int i;
    go <= 1'b1;
    go_rd <= rd;
    go_addr <= a;
    for (i = 0; i < 20 && taken !== 1'b1; i++) @(posedge clock);
    if (taken !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      @(negedge clock) go <= 1'b0;
    end
  endtask : cmd
  task automatic rd_burst(input logic [5:0] a, input logic live);
    int n;
    cmd(1'b1, a);
    for (n = 0; n < 5; n++) begin
      // beat 0 fires at the c# rise of cycle 6 and stands on data_out from cycle 7
      repeat (n == 0 ? 7 : 2) @(posedge clock);
      @(negedge clock);
      if (n < 4 && live) chk(data_out, mem[ba(a, n)]);
      chk(36'(data_oe), 36'(live && n < 4));
    end
  endtask : rd_burst
  task automatic wr_burst(input logic [5:0] a);
    int n;
    for (n = 0; n < 4; n++) begin
      seed = xs(seed);
      go_wd[n] = {seed[3:0], xs(seed)};
      mem[ba(a, n)] = go_wd[n];
    end
    cmd(1'b0, a);
    repeat (24) @(negedge clock);
  endtask : wr_burst
  task automatic wait_ready();
    int i;
    for (i = 0; i < 100 && dll_ready !== 1'b1; i++) @(negedge clock);
    chk(36'(dll_ready), 36'h1);
    if (dll_ready !== 1'b1) tally_and_finish();
  endtask : wait_ready
  // ============================================================
  // main sequence; all inputs defined from time zero
  initial begin
    rst_n = 1'b0;
    run = 1'b1;
    go = 1'b0;
    go_rd = 1'b0;
    go_addr = 6'h00;
    go_wd = '0;
    dll_off_n = 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock) rst_n <= 1'b1;
    wait_ready();
    // write then read back, corner start at the top of the array
    alist[0] = 6'h3F;
    for (int i = 1; i < 5; i++) begin
      seed = xs(seed);
      alist[i] = seed[5:0];
    end
    foreach (alist[i]) wr_burst(alist[i]);
    for (int i = 4; i >= 0; i--) rd_burst(alist[i], 1'b1);
    $display("test burst done");
    // a stop shorter than the limit keeps the lock
    @(negedge clock) run <= 1'b0;
    @(negedge clock) run <= 1'b1;
    repeat (8) @(negedge clock);
    chk(36'(dll_ready), 36'h1);
    // a long stop drops the lock; loads are ignored while it relocks
    run <= 1'b0;
    repeat (6) @(negedge clock);
    chk(36'(dll_ready), 36'h0);
    run <= 1'b1;
    rd_burst(alist[0], 1'b0);
    wait_ready();
    rd_burst(alist[0], 1'b1);
    $display("test clock stop done");
    // k at half rate for a while: slow but never stopped, so the lock stays
    repeat (24) @(negedge clock) run <= ~run;
    chk(36'(dll_ready), 36'h1);
    // rate changed, so reset through the disable pin now the clock is steady
    dll_off_n <= 1'b0;
    repeat (3) @(negedge clock);
    dll_off_n <= 1'b1;
    repeat (3) @(negedge clock);
    chk(36'(dll_ready), 36'h0);
    wait_ready();
    rd_burst(alist[1], 1'b1);
    $display("test disable pin done");
    tally_and_finish();
  end
endmodule : test_ddr_cio_sram_burst_and_dll_reset
`default_nettype wire
